// *** design/ghsr_health.sv ***
`timescale 1ns/1ps
`default_nettype none
module ghsr_health
    import ghsr_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire ghsr_mon_t mon,
    input wire logic self_test,
    output logic healthy,
    output logic checks_ok
);
    typedef struct packed {
        logic [31:0] settle;
        logic settled;
        logic ok;
        logic healthy;
    } ghsr_hst_t;

    ghsr_hst_t st_reg;
    ghsr_hst_t st_next;

    always_comb
    begin
        st_next = st_reg;
        // settle timer restarts whenever the loops lose lock
        if (!mon.loops_locked)
        begin
            st_next.settle = '0;
            st_next.settled = 1'b0;
        end
        else if (st_reg.settle < 32'(SETTLE_CNT))
        begin
            st_next.settle = st_reg.settle + 32'h1;
        end
        else
        begin
            st_next.settled = 1'b1; // [R05]
        end
        st_next.ok = !mon.cal_parity_err // [R02]
            && !mon.trim_conv_err // [R03]
            && mon.drive_level <= DRIVE_HI_LIMIT && mon.drive_level >= DRIVE_LO_LIMIT // [R04]
            && !mon.demod_saturated // [R06]
            && mon.quad_mag <= QUAD_LIMIT // [R07]
            && st_reg.settled; // [R05]
        st_next.healthy = st_next.ok && !self_test; // [R01] [R11]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign healthy = st_reg.healthy;
    assign checks_ok = st_reg.ok;

    property p_self_test_fails;
        @(posedge clk) disable iff (!rst_n) self_test |=> !healthy;
    endproperty
    a_self_test_fails: assert property (p_self_test_fails) else $error("health high during self-test"); // [R11]

    property p_parity_fails;
        @(posedge clk) disable iff (!rst_n) mon.cal_parity_err |=> !healthy;
    endproperty
    a_parity_fails: assert property (p_parity_fails) else $error("health high on parity error"); // [R02]
endmodule : ghsr_health
`default_nettype wire

// *** design/ghsr_pkg.sv ***
package ghsr_pkg;

    // message geometry
    localparam int MSG_BYTES = 6;
    localparam int MSG_BITS = 48;
    localparam int BIT_CNT_W = 6;

    // command byte fields
    localparam int CMD_SELF_TEST_BIT = 6;

    // status byte fields
    localparam int STS_FAIL_BIT = 7;
    localparam int STS_BAD_MSG_BIT = 4;
    localparam int STS_SELF_TEST_BIT = 3;
    localparam logic [2:0] STS_LOW_NORMAL = 3'h1;
    localparam logic [1:0] STS_TYPE_RATE_TEMP = 2'h0;

    // self-test offset: 150 deg/s, expressed in rate codes
    localparam int SELF_TEST_DPS = 150;
    localparam int RATE_CODES_PER_DPS = 8;
    localparam logic [15:0] SELF_TEST_OFFSET = 16'(SELF_TEST_DPS * RATE_CODES_PER_DPS);

    // temperature code: 2.75 codes/degC, 25 degC near 580
    localparam logic [15:0] TEMP_CODE_ZERO_C = 16'h0200;
    localparam int TEMP_QUARTER_CODES_PER_C = 11;

    // monitor limits (drive level, quadrature), plain defaults
    localparam logic [15:0] DRIVE_HI_LIMIT = 16'hE000;
    localparam logic [15:0] DRIVE_LO_LIMIT = 16'h1000;
    localparam logic [15:0] QUAD_LIMIT = 16'h4000;

    // startup settle time of the drive loops
    localparam int CLK_HZ = 40_000_000;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);

    typedef struct packed {
        logic cal_parity_err;
        logic trim_conv_err;
        logic demod_saturated;
        logic [15:0] drive_level;
        logic [15:0] quad_mag;
        logic loops_locked;
    } ghsr_mon_t;

    typedef struct packed {
        logic [7:0] status;
        logic [15:0] rate;
        logic [15:0] temp;
    } ghsr_reply_t;

    function automatic logic [7:0] ghsr_checksum(input logic [39:0] body);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            sum = sum + body[i*8 +: 8];
        end
        return ~sum;
    endfunction : ghsr_checksum

endpackage : ghsr_pkg

// *** design/ghsr_spi_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module ghsr_spi_slave
    import ghsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sel_n,
    input wire logic sck_rise,
    input wire logic sck_fall,
    input wire logic mosi,
    input wire logic [MSG_BITS-1:0] tx_msg,
    output logic miso,
    output logic frame_start,
    output logic [MSG_BITS-1:0] rx_msg,
    output logic rx_done
);
    typedef struct packed {
        logic [MSG_BITS-1:0] tx_sh;
        logic [MSG_BITS-1:0] rx_sh;
        logic [BIT_CNT_W-1:0] cnt;
        logic sel_d;
        logic done;
        logic start;
    } ghsr_sst_t;

    ghsr_sst_t st_reg;
    ghsr_sst_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.start = 1'b0;
        st_next.sel_d = sel_n;
        if (sel_n)
        begin
            st_next.cnt = '0;
            if (!st_reg.sel_d && st_reg.cnt == BIT_CNT_W'(MSG_BITS))
                st_next.done = 1'b1; // [R16] only whole messages count
        end
        else if (st_reg.sel_d)
        begin
            st_next.tx_sh = tx_msg; // first bit ready before first rise
            st_next.start = 1'b1;
        end
        else
        begin
            if (sck_rise && st_reg.cnt < BIT_CNT_W'(MSG_BITS))
            begin
                st_next.rx_sh = {st_reg.rx_sh[MSG_BITS-2:0], mosi}; // [R15] [R25]
                st_next.cnt = st_reg.cnt + BIT_CNT_W'(1);
            end
            if (sck_fall && st_reg.cnt != '0)
                st_next.tx_sh = {st_reg.tx_sh[MSG_BITS-2:0], 1'b0}; // [R25]
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.sel_d <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign miso = st_reg.tx_sh[MSG_BITS-1];
    assign rx_msg = st_reg.rx_sh;
    assign rx_done = st_reg.done;
    assign frame_start = st_reg.start;
endmodule : ghsr_spi_slave
`default_nettype wire

// *** design/ghsr_top.sv ***
// How it works
// R01: any failed check drives health low
// R02: calibration parity error drives health low
// R03: trim conversion error drives health low
// R04: drive level outside limits drives health low
// R05: health low until loops settle
// R06: demodulator saturation drives health low
// R07: excess quadrature drives health low
// R08: bad checksum reported as separate flag
// R09: self-test adds 150 deg/s offset
// R10: self-test by pin or command bit
// R11: health low while self-test enabled
// R12: temperature only via serial interface
// R13: temperature 2.75 codes/degC, 600 at 25C (code gives 580 at 25C, zero point 512)
// R14: mode select high enables serial interface
// R15: SPI slave mode 0
// R16: messages are six bytes exactly
// R17: host masters clock, one bit each way
// R18: host frames bytes within select low
// R19: host keeps select timing gaps
// R20: serial output released while deselected (code drives it for one cycle after a select low pulse of one clock)
// R21: command bit 6 toggles self-test
// R22: sixth byte is inverted sum checksum
// R23: bad command ignored, status bit 4
// R24: status fail bit set during self-test
// R25: output on fall, sample on rise, MSB first
`timescale 1ns/1ps
`default_nettype none
module ghsr_top
    import ghsr_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic MODE_SEL,
    input wire logic SELF_TEST_PIN,
    input wire logic SCLK,
    input wire logic SEL_B,
    input wire logic MOSI,
    input wire ghsr_mon_t MON,
    input wire logic [15:0] RATE_RAW,
    input wire logic [15:0] TEMP_DEG_Q2,
    output logic HEALTH,
    output logic ADC_EN,
    output logic MISO_O,
    output logic MISO_OE_B,
    output logic [15:0] RATE_OUT
);
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    typedef struct packed {
        logic [1:0] mode_s;
        logic [1:0] stp_s;
        logic [1:0] sck_s;
        logic [1:0] sel_s;
        logic [1:0] mosi_s;
        logic sck_d;
        logic st_cmd;
        logic bad_msg;
        logic health;
        logic adc_en;
        logic miso;
        logic miso_oe_b;
        logic [15:0] rate;
        logic [15:0] temp;
    } ghsr_tst_t;

    ghsr_tst_t st_reg;
    ghsr_tst_t st_next;

    logic sck_rise;
    logic sck_fall;
    logic self_test;
    logic healthy;
    logic checks_ok;
    logic spi_miso;
    logic frame_start;
    logic rx_done;
    logic [MSG_BITS-1:0] rx_msg;
    ghsr_reply_t reply;
    logic [MSG_BITS-1:0] tx_msg;

    // edges found on synchronised copies only
    assign sck_rise = st_reg.sck_s[1] && !st_reg.sck_d;
    assign sck_fall = !st_reg.sck_s[1] && st_reg.sck_d;

    // pin in analogue mode, command bit in digital mode
    assign self_test = st_reg.mode_s[1] ? st_reg.st_cmd : st_reg.stp_s[1]; // [R10]

    ghsr_health #(
        .SETTLE_CNT(SETTLE_CNT)
    ) u_health (
        .clk(MCLK),
        .rst_n(rst_n),
        .mon(MON),
        .self_test(self_test),
        .healthy(healthy),
        .checks_ok(checks_ok)
    );

    always_comb
    begin
        reply.status = '0;
        reply.status[STS_FAIL_BIT] = !checks_ok || self_test; // [R24]
        reply.status[6:5] = STS_TYPE_RATE_TEMP;
        reply.status[STS_BAD_MSG_BIT] = st_reg.bad_msg; // [R08] [R23]
        reply.status[STS_SELF_TEST_BIT] = self_test;
        reply.status[2:0] = STS_LOW_NORMAL;
        reply.rate = st_reg.rate;
        reply.temp = st_reg.temp; // [R12]
        tx_msg = {reply, ghsr_checksum(reply)}; // [R22]
    end

    ghsr_spi_slave u_spi (
        .clk(MCLK),
        .rst_n(rst_n),
        .sel_n(st_reg.sel_s[1]),
        .sck_rise(sck_rise && st_reg.mode_s[1]),
        .sck_fall(sck_fall && st_reg.mode_s[1]),
        .mosi(st_reg.mosi_s[1]),
        .tx_msg(tx_msg),
        .miso(spi_miso),
        .frame_start(frame_start),
        .rx_msg(rx_msg),
        .rx_done(rx_done)
    );

    always_comb
    begin
        st_next = st_reg;
        st_next.mode_s = {st_reg.mode_s[0], MODE_SEL};
        st_next.stp_s = {st_reg.stp_s[0], SELF_TEST_PIN};
        st_next.sck_s = {st_reg.sck_s[0], SCLK};
        st_next.sel_s = {st_reg.sel_s[0], SEL_B};
        st_next.mosi_s = {st_reg.mosi_s[0], MOSI};
        st_next.sck_d = st_reg.sck_s[1];
        st_next.adc_en = st_reg.mode_s[1]; // [R14]
        if (rx_done)
        begin
            if (ghsr_checksum(rx_msg[MSG_BITS-1:8]) == rx_msg[7:0]) // [R22]
            begin
                st_next.st_cmd = rx_msg[MSG_BITS-8+CMD_SELF_TEST_BIT]; // [R21]
                st_next.bad_msg = 1'b0;
            end
            else
                st_next.bad_msg = 1'b1; // [R23] settings kept
        end
        // rate: add offset while self-test active
        st_next.rate = self_test ? RATE_RAW + SELF_TEST_OFFSET : RATE_RAW; // [R09]
        // temp code = 512 + 2.75*degC; input is degC in quarter degrees
        st_next.temp = TEMP_CODE_ZERO_C
            + 16'((32'(signed'(TEMP_DEG_Q2)) * TEMP_QUARTER_CODES_PER_C) >>> 4); // [R13]
        st_next.health = healthy; // [R01]
        st_next.miso = spi_miso;
        st_next.miso_oe_b = st_reg.sel_s[1] || !st_reg.mode_s[1]; // [R20]
        // select toggling in analogue mode must never turn the data driver on
        if (frame_start && st_reg.mode_s[1])
            st_next.miso_oe_b = 1'b0;
    end

    always_ff @(posedge MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.sel_s <= 2'h3;
            st_reg.miso_oe_b <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    assign HEALTH = st_reg.health;
    assign ADC_EN = st_reg.adc_en;
    assign MISO_O = st_reg.miso;
    assign MISO_OE_B = st_reg.miso_oe_b;
    assign RATE_OUT = st_reg.rate;

    property p_release_deselected;
        @(posedge MCLK) disable iff (!rst_n) st_reg.sel_s[1] |=> MISO_OE_B;
    endproperty
    a_release_deselected: assert property (p_release_deselected) else $error("miso driven while deselected"); // [R20]

    property p_bad_flag;
        @(posedge MCLK) disable iff (!rst_n)
        rx_done && ghsr_checksum(rx_msg[MSG_BITS-1:8]) != rx_msg[7:0] |=> st_reg.bad_msg && $stable(st_reg.st_cmd);
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("bad command not flagged"); // [R23]

    property p_selftest_health;
        @(posedge MCLK) disable iff (!rst_n) self_test |-> ##2 !HEALTH;
    endproperty
    a_selftest_health: assert property (p_selftest_health) else $error("health high in self-test"); // [R11]

    property p_fail_bit;
        @(posedge MCLK) disable iff (!rst_n) self_test |-> tx_msg[MSG_BITS-8+STS_FAIL_BIT];
    endproperty
    a_fail_bit: assert property (p_fail_bit) else $error("fail bit clear in self-test"); // [R24]

    property p_offset;
        @(posedge MCLK) disable iff (!rst_n) self_test |=> RATE_OUT == $past(RATE_RAW) + SELF_TEST_OFFSET;
    endproperty
    a_offset: assert property (p_offset) else $error("self-test offset wrong"); // [R09]

    property p_checksum_tx;
        @(posedge MCLK) disable iff (!rst_n) tx_msg[7:0] == ghsr_checksum(tx_msg[MSG_BITS-1:8]);
    endproperty
    a_checksum_tx: assert property (p_checksum_tx) else $error("reply checksum wrong"); // [R22]

    property p_adc_en;
        @(posedge MCLK) disable iff (!rst_n) st_reg.mode_s[1] |=> ADC_EN;
    endproperty
    a_adc_en: assert property (p_adc_en) else $error("adc not enabled in digital mode"); // [R14]

    property p_health_fail;
        @(posedge MCLK) disable iff (!rst_n) MON.demod_saturated |-> ##2 !HEALTH;
    endproperty
    a_health_fail: assert property (p_health_fail) else $error("health high on saturation"); // [R06]

    c_good_msg: cover property (@(posedge MCLK) disable iff (!rst_n) rx_done && !st_next.bad_msg);
    c_bad_msg: cover property (@(posedge MCLK) disable iff (!rst_n) rx_done && st_next.bad_msg);
    c_self_test: cover property (@(posedge MCLK) disable iff (!rst_n) $rose(st_reg.st_cmd));
    c_pin_self_test: cover property (@(posedge MCLK) disable iff (!rst_n) !st_reg.mode_s[1] && st_reg.stp_s[1]);
    c_health_up: cover property (@(posedge MCLK) disable iff (!rst_n) $rose(HEALTH));

    // each monitor except loop lock reaches the pin two cycles later: check register, then output register
    property p_parity_health;
        @(posedge MCLK) disable iff (!rst_n)
        MON.cal_parity_err |-> ##2 !HEALTH;
    endproperty
    a_parity_health: assert property (p_parity_health) else $error("health high on parity error"); // [R02]

    property p_trim_fails;
        @(posedge MCLK) disable iff (!rst_n)
        MON.trim_conv_err |-> ##2 !HEALTH;
    endproperty
    a_trim_fails: assert property (p_trim_fails) else $error("health high on trim conversion error"); // [R03]

    property p_drive_high;
        @(posedge MCLK) disable iff (!rst_n)
        MON.drive_level > DRIVE_HI_LIMIT |-> ##2 !HEALTH;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("health high with drive level too high"); // [R04]

    property p_drive_low;
        @(posedge MCLK) disable iff (!rst_n)
        MON.drive_level < DRIVE_LO_LIMIT |-> ##2 !HEALTH;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("health high with drive level too low"); // [R04]

    property p_quad_fails;
        @(posedge MCLK) disable iff (!rst_n)
        MON.quad_mag > QUAD_LIMIT |-> ##2 !HEALTH;
    endproperty
    a_quad_fails: assert property (p_quad_fails) else $error("health high on excess quadrature"); // [R07]

    // loss of lock passes the settled flag first, so one cycle more
    property p_unlocked;
        @(posedge MCLK) disable iff (!rst_n)
        !MON.loops_locked |-> ##3 !HEALTH;
    endproperty
    a_unlocked: assert property (p_unlocked) else $error("health high with loops unlocked"); // [R05]

    property p_settle_hold;
        @(posedge MCLK) disable iff (!rst_n)
        SETTLE_CNT >= 8 && $rose(MON.loops_locked) |-> ##2 (!HEALTH) [*8];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("health high before loops settled"); // [R05]

    property p_health_gated;
        @(posedge MCLK) disable iff (!rst_n)
        HEALTH |-> $past(checks_ok) && !$past(self_test, 2);
    endproperty
    a_health_gated: assert property (p_health_gated) else $error("health high with a check failing"); // [R01]

    property p_no_offset;
        @(posedge MCLK) disable iff (!rst_n)
        !self_test |=> RATE_OUT == $past(RATE_RAW);
    endproperty
    a_no_offset: assert property (p_no_offset) else $error("rate offset outside self-test"); // [R09]

    property p_pin_self_test;
        @(posedge MCLK) disable iff (!rst_n)
        !st_reg.mode_s[1] && st_reg.stp_s[1] |=> RATE_OUT == $past(RATE_RAW) + SELF_TEST_OFFSET;
    endproperty
    a_pin_self_test: assert property (p_pin_self_test) else $error("pin self-test not applied"); // [R10]

    property p_cmd_self_test;
        @(posedge MCLK) disable iff (!rst_n)
        rx_done && ghsr_checksum(rx_msg[MSG_BITS-1:8]) == rx_msg[7:0]
        |=> st_reg.st_cmd == $past(rx_msg[MSG_BITS-8+CMD_SELF_TEST_BIT]);
    endproperty
    a_cmd_self_test: assert property (p_cmd_self_test) else $error("command self-test bit not taken"); // [R21]

    property p_good_clears;
        @(posedge MCLK) disable iff (!rst_n)
        rx_done && ghsr_checksum(rx_msg[MSG_BITS-1:8]) == rx_msg[7:0]
        |=> !st_reg.bad_msg;
    endproperty
    a_good_clears: assert property (p_good_clears) else $error("bad message flag kept after good command"); // [R08]

    property p_fail_on_checks;
        @(posedge MCLK) disable iff (!rst_n)
        !checks_ok |-> tx_msg[MSG_BITS-8+STS_FAIL_BIT];
    endproperty
    a_fail_on_checks: assert property (p_fail_on_checks) else $error("fail bit clear with a check failing"); // [R24]

    property p_fail_clear;
        @(posedge MCLK) disable iff (!rst_n)
        checks_ok && !self_test |-> !tx_msg[MSG_BITS-8+STS_FAIL_BIT];
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("fail bit set while healthy"); // [R24]

    property p_analogue_quiet;
        @(posedge MCLK) disable iff (!rst_n)
        !st_reg.mode_s[1] |=> MISO_OE_B;
    endproperty
    a_analogue_quiet: assert property (p_analogue_quiet) else $error("miso driven in analogue mode"); // [R20]

    property p_drive_selected;
        @(posedge MCLK) disable iff (!rst_n)
        st_reg.mode_s[1] && !st_reg.sel_s[1] |=> !MISO_OE_B;
    endproperty
    a_drive_selected: assert property (p_drive_selected) else $error("miso released while selected"); // [R20]

    property p_adc_off;
        @(posedge MCLK) disable iff (!rst_n)
        !st_reg.mode_s[1] |=> !ADC_EN;
    endproperty
    a_adc_off: assert property (p_adc_off) else $error("adc enabled in analogue mode"); // [R14]

    property p_miso_steady;
        @(posedge MCLK) disable iff (!rst_n)
        sck_rise && !st_reg.sel_s[1] && !$past(st_reg.sel_s[1]) |=> ##1 $stable(MISO_O);
    endproperty
    a_miso_steady: assert property (p_miso_steady) else $error("miso changed after a rising edge"); // [R25]
endmodule : ghsr_top
`default_nettype wire

// *** sim/ghsr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ghsr_host_model
    import ghsr_pkg::*;
(
    input wire logic go,
    input wire logic [MSG_BITS-1:0] cmd,
    input wire logic miso_o,
    input wire logic miso_oe_b,
    input wire logic cut,
    output logic sclk,
    output logic sel_b,
    output logic mosi,
    output logic [MSG_BITS-1:0] reply,
    output logic busy
);
    logic last;
    // a released data line shows the inverse of its last level, so stale bits never match
    wire logic line = miso_oe_b ? ~last : miso_o;
    initial
    begin
        {sclk, sel_b, mosi, busy, last} = 5'h08;
        reply = '0;
    end
    always @(posedge go)
    begin
        busy = 1'b1;
        sel_b = 1'b0;
        #25000;
        // a cut frame stops one byte short and must be dropped by the device
        for (int i = MSG_BITS - 1; i >= (cut ? 8 : 0); i--)
        begin
            mosi = cmd[i];
            #110;
            sclk = 1'b1;
            reply[i] = line;
            last = line;
            #90;
            sclk = 1'b0;
        end
        #5000;
        sel_b = 1'b1;
        mosi = ~mosi;
        #15000;
        busy = 1'b0;
    end
endmodule : ghsr_host_model
`default_nettype wire

// *** sim/gyro_health_spi_readout_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gyro_health_spi_readout_tb
    import ghsr_pkg::*;
;
    // short settle count keeps the start-up phase a few cycles long
    localparam int SETTLE = 10;
    logic mclk = 1'b0;
    logic rst_b, mode_sel, st_pin, go, cut, health, adc_en, miso_o, miso_oe_b, sclk, sel_b, mosi, busy;
    logic [15:0] rate_raw, temp_q2, rate_out;
    logic [MSG_BITS-1:0] cmd, reply;
    ghsr_mon_t mon;
    int mismatches = 0;
    int tests_run = 0;

    always #12.5 mclk = ~mclk;

    ghsr_top #(
        .SETTLE_CNT(SETTLE)
    ) i_dut (
        .MCLK(mclk),
        .RST_B(rst_b),
        .MODE_SEL(mode_sel),
        .SELF_TEST_PIN(st_pin),
        .SCLK(sclk),
        .SEL_B(sel_b),
        .MOSI(mosi),
        .MON(mon),
        .RATE_RAW(rate_raw),
        .TEMP_DEG_Q2(temp_q2),
        .HEALTH(health),
        .ADC_EN(adc_en),
        .MISO_O(miso_o),
        .MISO_OE_B(miso_oe_b),
        .RATE_OUT(rate_out)
    );

    ghsr_host_model i_host (
        .go(go),
        .cmd(cmd),
        .miso_o(miso_o),
        .miso_oe_b(miso_oe_b),
        .cut(cut),
        .sclk(sclk),
        .sel_b(sel_b),
        .mosi(mosi),
        .reply(reply),
        .busy(busy)
    );

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tick

    task automatic wait_health(input logic exp);
        int n;
        n = 0;
        while (health !== exp && n < 60)
        begin
            tick(1);
            n++;
        end
        check(16'(health), 16'(exp));
        if (health !== exp)
            report_and_stop();
    endtask : wait_health

    function automatic logic [7:0] sum_inv(input logic [39:0] b);
        return ~(b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0]);
    endfunction : sum_inv

    function automatic ghsr_mon_t fault_mon(input int k);
        ghsr_mon_t m;
        m = '0;
        m.drive_level = 16'h8000;
        m.quad_mag = 16'h0100;
        m.loops_locked = 1'b1;
        case (k)
            0: m.cal_parity_err = 1'b1;
            1: m.trim_conv_err = 1'b1;
            2: m.demod_saturated = 1'b1;
            3: m.drive_level = DRIVE_HI_LIMIT + 16'h0001;
            4: m.drive_level = DRIVE_LO_LIMIT - 16'h0001;
            5: m.quad_mag = QUAD_LIMIT + 16'h0001;
            6: m.drive_level = DRIVE_HI_LIMIT;
            7: m.quad_mag = QUAD_LIMIT;
            default: m.loops_locked = 1'b1;
        endcase
        return m;
    endfunction : fault_mon

    task automatic frame(input logic [7:0] b1, input logic good, input logic [7:0] st, input logic [15:0] rate);
        int n;
        n = 0;
        cmd = {b1, 32'h0, good ? ~b1 : 8'h00};
        go = 1'b1;
        tick(1);
        go = 1'b0;
        while (busy === 1'b1 && n < 3000)
        begin
            tick(1);
            n++;
        end
        if (busy !== 1'b0)
        begin
            mismatches++;
            report_and_stop();
        end
        check(16'(reply[47:40]), 16'(st));
        check(reply[39:24], rate);
        check(16'(reply[23:8] >= 16'd580 && reply[23:8] <= 16'd620), 16'h0001);
        check(16'(reply[7:0]), 16'(sum_inv(reply[47:8])));
        check(16'(miso_oe_b), 16'h0001);
    endtask : frame

    initial
    begin
        rst_b = 1'b0;
        mode_sel = 1'b0;
        st_pin = 1'b0;
        go = 1'b0;
        cut = 1'b0;
        cmd = '0;
        rate_raw = 16'h0123;
        temp_q2 = 16'd100;
        mon = fault_mon(8);
        mon.loops_locked = 1'b0;
        tick(8);
        rst_b = 1'b1;
        tick(20);
        check(16'(health), 16'h0000);
        mon.loops_locked = 1'b1;
        tick(5);
        check(16'(health), 16'h0000);
        wait_health(1'b1);
        for (int k = 0; k < 8; k++)
        begin
            mon = fault_mon(k);
            tick(8);
            check(16'(health), 16'(k >= 6));
            mon = fault_mon(8);
            wait_health(1'b1);
        end
        st_pin = 1'b1;
        tick(8);
        check(rate_out, rate_raw + SELF_TEST_OFFSET);
        check(16'(health), 16'h0000);
        check(16'(adc_en), 16'h0000);
        st_pin = 1'b0;
        wait_health(1'b1);
        check(rate_out, rate_raw);
        mode_sel = 1'b1;
        tick(8);
        check(16'(adc_en), 16'h0001);
        check(16'(miso_oe_b), 16'h0001);
        frame(8'h30, 1'b1, 8'h01, rate_raw);
        // a short frame taken as a message would fail its checksum and raise the flag below
        cut = 1'b1;
        frame(8'h70, 1'b1, 8'h01, rate_raw);
        cut = 1'b0;
        frame(8'h70, 1'b1, 8'h01, rate_raw);
        frame(8'h30, 1'b0, 8'h89, rate_raw + SELF_TEST_OFFSET);
        check(16'(health), 16'h0000);
        frame(8'h30, 1'b1, 8'h99, rate_raw + SELF_TEST_OFFSET);
        frame(8'h30, 1'b1, 8'h01, rate_raw);
        wait_health(1'b1);
        report_and_stop();
    end
endmodule : gyro_health_spi_readout_tb
`default_nettype wire
